/* File: rtl/dcog_pkg.sv */
// constants and register layout of the divided clock output generator
package dcog_pkg;

  // oscillator and core clock rates
  localparam int          OSC_FREQ_KHZ   = 24000;
  localparam int          CORE_FREQ_KHZ  = 125000;
  // accumulator for 2x oscillator half-period ticks
  localparam int          PHASE_W        = 18;
  localparam logic [17:0] HALF_TICK_STEP = 18'(2 * OSC_FREQ_KHZ);
  localparam logic [17:0] PHASE_MODULUS  = 18'(CORE_FREQ_KHZ);

  // register addresses on the special-function register bus
  localparam logic [7:0]  OUT_CFG_ADDR   = 8'h8F;
  localparam logic [7:0]  PORT_SET_ADDR  = 8'hB6;
  localparam logic [7:0]  OUT_CFG_RESET  = 8'h00;
  localparam logic [7:0]  PORT_SET_RESET = 8'h00;
  // reserved port settings bits 1:0 stay zero
  localparam logic [7:0]  PORT_WR_MASK   = 8'hFC;

  // output_clock_config fields
  localparam int          CLEAR_BIT      = 7;
  localparam int          IDLE_BIT       = 7;
  localparam int          INVERT_BIT     = 6;
  localparam int          BALANCE_BIT    = 5;
  localparam int          DIV_MSB        = 4;
  localparam int          DIV_LSB        = 0;
  localparam int          DIV_W          = 5;
  localparam int          CNT_W          = 6;

  // port settings fields
  localparam int          GATE_BIT       = 3;
  localparam int          ROUTE_G4_BIT   = 4;
  localparam int          ROUTE_G6_BIT   = 5;

  // smallest effective divide factor
  localparam logic [4:0]  DIV_MIN        = 5'h01;

endpackage : dcog_pkg

/* File: rtl/dcog_core_if.sv */
// carrier between the register front end and the divider core
`timescale 1ns/1ps
interface dcog_core_if;
  import dcog_pkg::*;

  logic             halfTick;
  logic             enable;
  logic             balance;
  logic             clear;
  logic [DIV_W-1:0] divPending;
  logic             wave;
  logic             idle;

  modport front (output halfTick, output enable, output balance, output clear,
                 output divPending, input wave, input idle);
  modport core  (input halfTick, input enable, input balance, input clear,
                 input divPending, output wave, output idle);
endinterface : dcog_core_if

/* File: rtl/dcog_divider.sv */
// divider core: counts oscillator half periods and shapes the waveform
`timescale 1ns/1ps
module dcog_divider
  import dcog_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  dcog_core_if.core bus
);

  typedef struct packed {
    logic             running;
    logic [CNT_W-1:0] cnt;
    logic [DIV_W-1:0] activeDiv;
    logic             wave;
  } dcog_div_state_t;

  dcog_div_state_t s_q;
  dcog_div_state_t s_d;

  // factors 0 and 1 both mean pass-through
  function automatic logic [DIV_W-1:0] effDiv(input logic [DIV_W-1:0] d);
    effDiv = (d <= DIV_MIN) ? DIV_MIN : d;
  endfunction : effDiv

  logic [CNT_W-1:0] lastCnt;
  logic [CNT_W-1:0] highFrom;

  always_comb begin
    lastCnt = CNT_W'({s_q.activeDiv, 1'b0} - 6'h01);
    // balanced, or factor 1: N ticks low, N high; plain halving would
    // leave factor 1 stuck high instead of passing the oscillator through
    if (bus.balance || (s_q.activeDiv == DIV_MIN)) begin
      highFrom = CNT_W'({1'b0, s_q.activeDiv});
    end else begin
      // floor(N/2) cycles low then ceil(N/2) high
      highFrom = CNT_W'({1'b0, s_q.activeDiv[DIV_W-1:1], 1'b0});
    end

    s_d = s_q;
    if (bus.clear) begin
      // new factor taken at once, output forced low
      s_d.running   = 1'b0;
      s_d.cnt       = '0;
      s_d.activeDiv = effDiv(bus.divPending);
    end else if (bus.halfTick) begin
      if (!s_q.running) begin
        if (bus.enable) begin
          s_d.running   = 1'b1;
          s_d.cnt       = '0;
          s_d.activeDiv = effDiv(bus.divPending);
        end
      end else if (s_q.cnt == lastCnt) begin
        // period boundary: besides clear, only here a new factor or a stop is taken
        s_d.cnt       = '0;
        s_d.activeDiv = effDiv(bus.divPending);
        s_d.running   = bus.enable;
      end else begin
        s_d.cnt = CNT_W'(s_q.cnt + 6'h01);
      end
    end
    s_d.wave = s_d.running && (s_d.cnt >= highFrom);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{running: 1'b0, cnt: '0, activeDiv: DIV_MIN, wave: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.wave = s_q.wave;
  assign bus.idle = !s_q.running;

endmodule : dcog_divider

/* File: rtl/dcog_top.sv */
// divided clock output generator: register front end, oscillator tick and output stage
// Operation
// - clock comes from the 24 MHz oscillator, not the system divider.
// - divide ratios 1 to 31, giving 24 MHz down to about 774 kHz.
// - without clear, a new factor is taken only when the running period completes.
// - pin output is governed by the gate bit and the route bits.
// - writing 1 to bit 7 resets the divider and drives the clock low, or high when inverted.
// - the clear pulse is registered, aligned with the config register update.
// - reading bit 7 returns idle status, 1 meaning the divider is idle.
// - clear written with a new factor switches ratio immediately.
// - invert is the last stage; stopped level is 0, or 1 when inverted.
// - invert changed while running acts at once, a short pulse may result.
// - balance bit gives near 1:1 duty for every divisor.
// - without balance, odd ratios from 3 up have low half one cycle shorter.
// - factors 0 and 1 pass the oscillator through; larger values divide.
// - on disable the period in progress finishes, then idle is reported.
// - two route bits make GPIO4 and GPIO6 clock pins, independently.
// - the gate bit only gates the waveform, stopping low (high when inverted) after the period.
`timescale 1ns/1ps
module dcog_top
  import dcog_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic [7:0] sfrWrData,
  output logic      [7:0] sfrRdData,
  output logic            clkOut,
  output logic            gpio4ClkSel,
  output logic            gpio6ClkSel
);

  typedef struct packed {
    logic               wrStb;
    logic [7:0]         wrAddr;
    logic [7:0]         wrData;
    logic [6:0]         cfg;
    logic [7:0]         portSet;
    logic               clrPulse;
    logic [PHASE_W-1:0] phase;
    logic               halfTick;
    logic [7:0]         rdData;
    logic               clkOut;
    logic               g4Sel;
    logic               g6Sel;
  } dcog_top_state_t;

  dcog_top_state_t s_q;
  dcog_top_state_t s_d;

  dcog_core_if coreBus ();

  dcog_divider u_divider (
    .core_clk (core_clk),
    .rst      (rst),
    .bus      (coreBus.core)
  );

  // register and gate bits feed the core straight from flops
  assign coreBus.halfTick   = s_q.halfTick;
  assign coreBus.enable     = s_q.portSet[GATE_BIT];
  assign coreBus.balance    = s_q.cfg[BALANCE_BIT];
  assign coreBus.clear      = s_q.clrPulse;
  assign coreBus.divPending = s_q.cfg[DIV_MSB:DIV_LSB];

  logic [PHASE_W-1:0] phaseSum;
  logic               cfgHit;
  logic               portHit;

  always_comb begin
    s_d = s_q;

    // oscillator half periods from a fractional accumulator; the edge
    // timing jitters by one core cycle, the average rate is exact
    phaseSum   = PHASE_W'(s_q.phase + HALF_TICK_STEP);
    s_d.halfTick = 1'b0;
    if (phaseSum >= PHASE_MODULUS) begin
      s_d.phase    = PHASE_W'(phaseSum - PHASE_MODULUS);
      s_d.halfTick = 1'b1;
    end else begin
      s_d.phase = phaseSum;
    end

    // bus write is captured first, then applied one cycle later
    s_d.wrStb  = sfrWrEn;
    s_d.wrAddr = sfrAddr;
    s_d.wrData = sfrWrData;

    cfgHit  = s_q.wrStb && (s_q.wrAddr == OUT_CFG_ADDR);
    portHit = s_q.wrStb && (s_q.wrAddr == PORT_SET_ADDR);

    // clear bit is a pulse, never stored
    s_d.clrPulse = cfgHit && s_q.wrData[CLEAR_BIT];
    if (cfgHit) begin
      s_d.cfg = s_q.wrData[6:0];
    end
    if (portHit) begin
      s_d.portSet = s_q.wrData & PORT_WR_MASK;
    end

    // read data registered from the address of the current cycle
    if (sfrAddr == OUT_CFG_ADDR) begin
      s_d.rdData = {coreBus.idle, s_q.cfg};
    end else if (sfrAddr == PORT_SET_ADDR) begin
      s_d.rdData = s_q.portSet;
    end else begin
      s_d.rdData = 8'h00;
    end

    // inversion is the final stage and follows the bit at once
    s_d.clkOut = coreBus.wave ^ s_q.cfg[INVERT_BIT];
    // pin routing is independent of the waveform gate
    s_d.g4Sel  = s_q.portSet[ROUTE_G4_BIT];
    s_d.g6Sel  = s_q.portSet[ROUTE_G6_BIT];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{wrStb: 1'b0, wrAddr: 8'h00, wrData: 8'h00,
               cfg: OUT_CFG_RESET[6:0], portSet: PORT_SET_RESET,
               clrPulse: 1'b0, phase: '0, halfTick: 1'b0,
               rdData: 8'h00, clkOut: 1'b0, g4Sel: 1'b0, g6Sel: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sfrRdData   = s_q.rdData;
  assign clkOut      = s_q.clkOut;
  assign gpio4ClkSel = s_q.g4Sel;
  assign gpio6ClkSel = s_q.g6Sel;

endmodule : dcog_top

/* File: verif/dcog_clk_sink.sv */
// far-side chip model: measures the clock it receives
`timescale 1ns/1ps
module dcog_clk_sink (
  input  wire logic core_clk,
  input  wire logic clkIn,
  output int        highLen,
  output int        lowLen,
  output int        riseCnt
);
  int   run  = 0;
  logic last = 1'b0;
  // run lengths in core cycles; a clock change restarts the count
  always @(posedge core_clk) begin
    if (clkIn !== last) begin
      if (last) begin
        highLen = run;
      end else begin
        lowLen = run;
      end
      if (clkIn) begin
        riseCnt++;
      end
      run = 1;
    end else begin
      run++;
    end
    last = clkIn;
  end
endmodule : dcog_clk_sink

/* File: verif/dcog_top_assertions.sv */
// port checker of the divided clock output generator
`timescale 1ns/1ps
module dcog_checker
  import dcog_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic [7:0] sfrRdData,
  input wire logic       clkOut,
  input wire logic       gpio4ClkSel,
  input wire logic       gpio6ClkSel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_port; sfrWrEn && sfrAddr == PORT_SET_ADDR ##1 !sfrWrEn [*3]; endsequence
  sequence s_clr; sfrWrEn && sfrAddr == OUT_CFG_ADDR && sfrWrData[CLEAR_BIT]; endsequence
  property p_rd_unmap;
    sfrAddr != OUT_CFG_ADDR && sfrAddr != PORT_SET_ADDR |=> sfrRdData == 8'h00;
  endproperty
  property p_resv; sfrAddr == PORT_SET_ADDR |=> sfrRdData[1:0] == 2'b00; endproperty
  property p_route4; s_port |-> gpio4ClkSel == $past(sfrWrData[ROUTE_G4_BIT], 3); endproperty
  property p_route6; s_port |-> gpio6ClkSel == $past(sfrWrData[ROUTE_G6_BIT], 3); endproperty
  property p_clr_lo; s_clr and !sfrWrData[INVERT_BIT] |-> ##[2:4] !clkOut; endproperty
  property p_clr_hi; s_clr and sfrWrData[INVERT_BIT] |-> ##[2:4] clkOut; endproperty
  // idle seen twice in a row: the output must rest at the inversion level
  property p_idle_lvl;
    $past(sfrAddr) == OUT_CFG_ADDR && $past(sfrAddr, 2) == OUT_CFG_ADDR
      && sfrRdData[IDLE_BIT] && $stable(sfrRdData) |-> clkOut == sfrRdData[INVERT_BIT];
  endproperty
  // oscillator ticks are never in adjacent core cycles, so no one-cycle pulses
  property p_min_pulse; !sfrWrEn [*5] ##1 $changed(clkOut) |=> $stable(clkOut); endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
  a_resv: assert property (p_resv) else $error("reserved bits set");
  a_route4: assert property (p_route4) else $error("gpio4 route wrong");
  a_route6: assert property (p_route6) else $error("gpio6 route wrong");
  a_clr_lo: assert property (p_clr_lo) else $error("clear left clock high");
  a_clr_hi: assert property (p_clr_hi) else $error("inverted clear not high");
  a_idle_lvl: assert property (p_idle_lvl) else $error("idle level wrong");
  a_min_pulse: assert property (p_min_pulse) else $error("short pulse");
  c_run: cover property ($rose(clkOut));
  c_idle: cover property ($past(sfrAddr) == OUT_CFG_ADDR && sfrRdData[IDLE_BIT]);
  c_clr: cover property (s_clr);
endmodule : dcog_checker
bind dcog_top dcog_checker i_chk (.core_clk, .rst, .sfrAddr, .sfrWrEn, .sfrWrData,
  .sfrRdData, .clkOut, .gpio4ClkSel, .gpio6ClkSel);

/* File: verif/dcog_top_tb.sv */
// self-checking bench of the divided clock output generator
`timescale 1ns/1ps
module dcog_top_tb;
  import dcog_pkg::*;
  logic       core_clk = 0, rst = 1, sfrWrEn = 0, clkOut, gpio4ClkSel, gpio6ClkSel;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData, d;
  int         errors = 0, samples_checked = 0, highLen, lowLen, riseCnt, i;
  always #4 core_clk = ~core_clk;
  dcog_top i_dut (.core_clk, .rst, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdData, .clkOut,
    .gpio4ClkSel, .gpio6ClkSel);
  dcog_clk_sink i_sink (.core_clk, .clkIn(clkOut), .highLen, .lowLen, .riseCnt);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    {sfrAddr, sfrWrData, sfrWrEn} = {a, v, 1'b1};
    @(negedge core_clk);
    sfrWrEn = 0;
  endtask : wr
  // waits out the two-edge write latency before reading
  task automatic rd(input logic [7:0] a);
    repeat (2) @(negedge core_clk);
    sfrAddr = a;
    @(negedge core_clk);
    d = sfrRdData;
  endtask : rd
  task automatic rise(input int n);
    n += riseCnt;
    for (i = 0; i < 3000 && riseCnt < n; i++) @(negedge core_clk);
    if (riseCnt < n) begin
      errors++;
      print_verdict();
    end
  endtask : rise
  // ticks run at 48 MHz; one core cycle of jitter is allowed
  function automatic logic near(input int seen, input int ticks);
    return (seen - (ticks * 125 + 24) / 48) inside {[-1:1]};
  endfunction : near
  task automatic t_reset();
    rd(OUT_CFG_ADDR);
    check(d, 8'h80);
    rd(PORT_SET_ADDR);
    check(d, PORT_SET_RESET);
    check(clkOut, 1'b0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_route();
    wr(PORT_SET_ADDR, 8'h33);
    rd(PORT_SET_ADDR);
    check(d, 8'h30);
    check({gpio6ClkSel, gpio4ClkSel, clkOut}, 3'b110);
    wr(PORT_SET_ADDR, 8'h18);
    rd(PORT_SET_ADDR);
    check({gpio6ClkSel, gpio4ClkSel}, 2'b01);
    $display("t_route done");
  endtask : t_route
  task automatic t_div();
    logic [7:0] cfg [6] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h1F, 8'h25};
    int         lo [6]  = '{1, 1, 2, 4, 30, 5};
    int         hi [6]  = '{1, 1, 2, 6, 32, 5};
    foreach (cfg[k]) begin
      wr(OUT_CFG_ADDR, cfg[k]);
      // one spare rise: the old period in progress may still run out first
      rise(4);
      check(near(lowLen, lo[k]), 1'b1);
      check(near(highLen, hi[k]), 1'b1);
      rd(OUT_CFG_ADDR);
      check(d, cfg[k]);
    end
    $display("t_div done");
  endtask : t_div
  task automatic t_clear();
    wr(OUT_CFG_ADDR, 8'h1F);
    rise(3);
    // clear in the high half, so a missed clear would leave the output high
    for (int k = 0; k < 200 && clkOut !== 1'b1; k++) @(negedge core_clk);
    wr(OUT_CFG_ADDR, 8'h82);
    repeat (4) @(negedge core_clk);
    check(clkOut, 1'b0);
    rise(3);
    check(near(highLen, 2), 1'b1);
    check(near(lowLen, 2), 1'b1);
    $display("t_clear done");
  endtask : t_clear
  task automatic t_stop();
    wr(PORT_SET_ADDR, 8'h10);
    d = 8'h00;
    for (int k = 0; k < 50 && !d[7]; k++) rd(OUT_CFG_ADDR);
    check({d[7], clkOut}, 2'b10);
    check(near(highLen, 2), 1'b1);
    check(near(lowLen, 2), 1'b1);
    wr(OUT_CFG_ADDR, 8'hC2);
    rd(OUT_CFG_ADDR);
    check({d, clkOut}, 9'h185);
    wr(8'hB1, 8'hFF);
    rd(8'hB1);
    check(d, 8'h00);
    $display("t_stop done");
  endtask : t_stop
  initial begin
    repeat (3) @(negedge core_clk);
    rst = 0;
    t_reset();
    t_route();
    t_div();
    t_clear();
    t_stop();
    print_verdict();
  end
endmodule : dcog_top_tb
